// [rtl/qld_driver_ctrl.sv]
/*
 * Control and fault reporting of a four-channel low-side driver:
 * serial command port, parallel inputs, fault latches, low duty cycle
 * protection, overvoltage shutdown, Wishbone status and interrupt.
 * Assumes all pins are synchronous to clk and the shift clock is far
 * slower than clk.
 */
`timescale 1ns/1ps
module qld_driver_ctrl #(
    parameter int SENSE_CYC = qld_pkg::SENSE_CYC,
    parameter int DUTY_TICK_CYC = qld_pkg::DUTY_TICK_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic serIn,
    output logic serOut,
    output logic serOutOe,
    input wire logic [qld_pkg::CHANNELS-1:0] parCtl,
    output logic [qld_pkg::CHANNELS-1:0] drvCh,
    input wire logic [qld_pkg::CHANNELS-1:0] ocDet,
    input wire logic [qld_pkg::CHANNELS-1:0] olDet,
    input wire logic overvoltage,
    output logic statusOut,
    output logic statusOe,
    input wire qld_pkg::qld_wb_req_t wbReq,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    output logic irq
);
    import qld_pkg::*;

    localparam int TW = $clog2(DUTY_TICK_CYC);
    localparam logic [TW-1:0] TICK_LAST = TW'(DUTY_TICK_CYC - 1);
    localparam logic [TW-1:0] TONE = TW'(1);
    localparam logic [5:0] SONE = 6'h01;
    localparam logic [4:0] BONE = 5'h01;

    // ************************************************************
    // Edge detection on the serial pins and the overvoltage input
    // ************************************************************
    logic sclkPrev_reg, selPrev_reg, ovPrev_reg;
    logic selFall, selRise, sclkRise, sclkFall;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclkPrev_reg <= 1'b0;
            selPrev_reg <= 1'b1;
            ovPrev_reg <= 1'b0;
        end else begin
            sclkPrev_reg <= sclk;
            selPrev_reg <= select_n;
            ovPrev_reg <= overvoltage;
        end
    end

    // Strobes used by the shift logic
    assign selFall = selPrev_reg && !select_n;
    assign selRise = !selPrev_reg && select_n;
    assign sclkRise = !sclkPrev_reg && sclk && !select_n;
    assign sclkFall = sclkPrev_reg && !sclk && !select_n;

    // ************************************************************
    // Duty cycle timebase
    // ************************************************************
    logic [TW-1:0] tick_reg, tick_next;
    logic [5:0] slot_reg, slot_next;
    logic dutyOn;

    // Divider pulse advances a 64-slot phase
    always_comb begin
        tick_next = (tick_reg == TICK_LAST) ? '0 : tick_reg + TONE;
        slot_next = (tick_reg == TICK_LAST) ? slot_reg + SONE : slot_reg;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_reg <= '0;
            slot_reg <= '0;
        end else begin
            tick_reg <= tick_next;
            slot_reg <= slot_next;
        end
    end

    assign dutyOn = (slot_reg == DUTY_ON_SLOT);

    // ************************************************************
    // Channel sensing
    // ************************************************************
    logic [CHANNELS-1:0] cmd_reg, want, ocHit, olHit, ocLimit;

    assign want = cmd_reg | parCtl;

    generate
        for (genvar i = 0; i < CHANNELS; i++) begin : gChan
            qld_chan_sense #(
                .SENSE_CYC(SENSE_CYC)
            ) uSense (
                .clk(clk),
                .reset_n(reset_n),
                .chanOn(want[i] && !overvoltage),
                .ocDet(ocDet[i]),
                .olDet(olDet[i]),
                .ocHit(ocHit[i]),
                .olHit(olHit[i])
            );
        end
    endgenerate

    // Overcurrent confirmed, still present, channel commanded
    assign ocLimit = ocHit & ocDet & want;

    // ************************************************************
    // Serial port and fault latches
    // ************************************************************
    qld_spi_state_t spiState_reg, spiState_next;
    logic [WORD_BITS-1:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [BYTE_BITS-1:0] echo_reg, echo_next;
    logic [4:0] bits_reg, bits_next;
    logic [CHANNELS-1:0] cmd_next, fault_reg, fault_next;
    logic so_reg, so_next;

    always_comb begin
        spiState_next = spiState_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        echo_next = echo_reg;
        bits_next = bits_reg;
        cmd_next = cmd_reg;
        so_next = so_reg;
        // Faults held until select rises, new hits always win
        fault_next = selRise ? '0 : fault_reg;
        fault_next = fault_next | ocHit | olHit;
        case (spiState_reg)
            SPI_IDLE: begin
                if (selFall) begin
                    spiState_next = SPI_SHIFT;
                    bits_next = '0;
                    // Fault byte first, then echo of previous frame
                    tx_next = {FAULT_PAD, fault_reg, echo_reg};
                    so_next = tx_next[WORD_BITS-1];
                end
            end
            SPI_SHIFT: begin
                if (selRise) begin
                    spiState_next = SPI_IDLE;
                    cmd_next = rx_reg[CHANNELS-1:0];
                    echo_next = (bits_reg >= LONG_XFER_BITS) ?
                        rx_reg[WORD_BITS-1:BYTE_BITS] :
                        rx_reg[BYTE_BITS-1:0];
                end else begin
                    if (sclkRise) begin
                        rx_next = {rx_reg[WORD_BITS-2:0], serIn};
                        if (bits_reg != LONG_XFER_BITS) begin
                            bits_next = bits_reg + BONE;
                        end
                    end
                    if (sclkFall) begin
                        tx_next = {tx_reg[WORD_BITS-2:0], 1'b0};
                        so_next = tx_reg[WORD_BITS-2];
                    end
                end
            end
            default: begin
                spiState_next = SPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spiState_reg <= SPI_IDLE;
            rx_reg <= '0;
            tx_reg <= '0;
            echo_reg <= '0;
            bits_reg <= '0;
            cmd_reg <= '0;
            so_reg <= 1'b0;
            fault_reg <= '0;
        end else begin
            spiState_reg <= spiState_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            echo_reg <= echo_next;
            bits_reg <= bits_next;
            cmd_reg <= cmd_next;
            so_reg <= so_next;
            fault_reg <= fault_next;
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    logic [CHANNELS-1:0] drv_next;
    logic oe_next, stat_next;

    always_comb begin
        // Overvoltage wins over every command source
        drv_next = overvoltage ? '0 :
            (want & ~(ocLimit & {CHANNELS{!dutyOn}}));
        oe_next = !select_n;
        stat_next = (fault_next != '0);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drvCh <= '0;
            serOutOe <= 1'b0;
            statusOe <= 1'b0;
            statusOut <= 1'b0;
        end else begin
            drvCh <= drv_next;
            serOutOe <= oe_next;
            statusOe <= stat_next;
            statusOut <= 1'b0;
        end
    end

    assign serOut = so_reg;

    // ************************************************************
    // Wishbone registers and interrupt
    // ************************************************************
    logic [EVT_BITS-1:0] evt_reg, evt_next, en_reg, en_next, evtSet;
    logic [31:0] dat_next;
    logic ack_next, irq_next, acc, wr;

    assign acc = wbReq.cyc && wbReq.stb && !wbAck;
    assign wr = acc && wbReq.we && wbReq.sel[0];
    assign evtSet = {selRise, overvoltage && !ovPrev_reg,
        fault_next & ~fault_reg};

    always_comb begin
        evt_next = evt_reg;
        en_next = en_reg;
        dat_next = '0;
        ack_next = acc;
        if (wr && wbReq.adr == ADR_CLEAR) begin
            evt_next = evt_reg & ~wbReq.dat[EVT_BITS-1:0];
        end else if (wr && wbReq.adr == ADR_ENABLE) begin
            en_next = wbReq.dat[EVT_BITS-1:0];
        end
        // Set wins over a clear in the same cycle
        evt_next = evt_next | evtSet;
        if (acc && !wbReq.we) begin
            if (wbReq.adr == ADR_STATUS) begin
                dat_next = {26'h0, evt_reg};
            end else if (wbReq.adr == ADR_ENABLE) begin
                dat_next = {26'h0, en_reg};
            end else if (wbReq.adr == ADR_STATE) begin
                dat_next = {19'h0, overvoltage, cmd_reg, fault_reg, drvCh};
            end
        end
        irq_next = ((evt_next & en_next) != '0);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evt_reg <= EVT_RESET;
            en_reg <= EVT_RESET;
            wbDatOut <= '0;
            wbAck <= 1'b0;
            irq <= 1'b0;
        end else begin
            evt_reg <= evt_next;
            en_reg <= en_next;
            wbDatOut <= dat_next;
            wbAck <= ack_next;
            irq <= irq_next;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_ov_all_off: assert property (@(posedge clk) disable iff (!reset_n)
        overvoltage |=> drvCh == '0)
        else $error("channel driven during overvoltage");

    a_cmd_follow: assert property (@(posedge clk) disable iff (!reset_n)
        (!overvoltage && ocLimit == '0) |=> drvCh == $past(want))
        else $error("channel does not follow commands");

    a_oc_sets_fault: assert property (@(posedge clk) disable iff (!reset_n)
        ocHit != '0 |=> (fault_reg & $past(ocHit)) == $past(ocHit))
        else $error("overcurrent did not set fault");

    a_fault_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !selRise |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
        else $error("fault dropped before select rise");

    a_duty_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (!dutyOn && ocLimit != '0) |=> (drvCh & $past(ocLimit)) == '0)
        else $error("limited channel driven outside duty slot");

    a_ol_sets_fault: assert property (@(posedge clk) disable iff (!reset_n)
        olHit != '0 |=> (fault_reg & $past(olHit)) == $past(olHit))
        else $error("open load did not set fault");

    a_so_release: assert property (@(posedge clk) disable iff (!reset_n)
        select_n ##1 select_n |=> !serOutOe)
        else $error("serial output driven while deselected");

    a_so_on_fall: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(serOut) |-> $past(sclkFall) || $past(selFall))
        else $error("serial output changed off a falling edge");

    a_cmd_latch: assert property (@(posedge clk) disable iff (!reset_n)
        (selRise && spiState_reg == SPI_SHIFT) |=>
        cmd_reg == $past(rx_reg[CHANNELS-1:0]))
        else $error("command latch missed select rise");

    a_status_low: assert property (@(posedge clk) disable iff (!reset_n)
        fault_reg != '0 |-> statusOe)
        else $error("status not pulled with fault present");

    a_fault_capture: assert property (@(posedge clk) disable iff (!reset_n)
        (selFall && spiState_reg == SPI_IDLE) |=>
        tx_reg[WORD_BITS-1:BYTE_BITS] == {FAULT_PAD, $past(fault_reg)})
        else $error("faults not captured at select fall");

endmodule

// [shared/qld_pkg.sv]
/*
 * Constants, types and field layouts shared by the quad low-side driver
 * control block and its channel sense module.
 * Assumes a single 200 MHz clock and a classic Wishbone register bus.
 */
// Functional notes
// - Overvoltage forces all four channels off immediately.
// - After overvoltage clears, channels follow serial and parallel commands again.
// - Overcurrent lasting the sense time sets the channel fault bit.
// - Overcurrent fault bit holds until the next select rising edge.
// - Persisting overcurrent on a commanded channel gives low duty cycle drive.
// - Open load on an off channel for the sense time sets its fault.
// - Words of 8 or 16 bits, MSB first, sampled on shift clock rise.
// - Serial output driven only while select is low, else released.
// - Serial output data changes on shift clock falling edges.
// - Returned word starts at bit 7; bits 0 to 3 are channel faults.
// - In 8-bit transfers fault bits read one when faulted, zero otherwise.
// - Select rising edge moves last four received bits to command latches.
// - Channel is on when its serial bit or parallel input is high.
// - Open-drain status pulled low while any channel has a fault.
// - Command bits 3 to 0 drive channels 3 to 0; bits 7 to 4 ignored.
// - Select falling edge captures faults into the serial shift register.
// - 16-bit transfer returns fault byte then previous first eight bits.
package qld_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SENSE_TIME_NS = 62500;
    localparam int SENSE_CYC = (SENSE_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int DUTY_TICK_CYC = 100;
    localparam int DUTY_SLOTS_LOG2 = 6;
    localparam logic [5:0] DUTY_ON_SLOT = 6'h00;

    // ************************************************************
    // Serial port layout
    // ************************************************************
    localparam int CHANNELS = 4;
    localparam int WORD_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam logic [4:0] LONG_XFER_BITS = 5'h10;
    localparam logic [3:0] FAULT_PAD = 4'h0;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_CLEAR = 8'h04;
    localparam logic [7:0] ADR_ENABLE = 8'h08;
    localparam logic [7:0] ADR_STATE = 8'h0C;
    localparam int EVT_BITS = 6;
    localparam int EVT_OV = 4;
    localparam int EVT_XFER = 5;
    localparam logic [5:0] EVT_RESET = 6'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b01,
        SPI_SHIFT = 2'b10
    } qld_spi_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } qld_wb_req_t;

endpackage

// [rtl/qld_chan_sense.sv]
/*
 * Per-channel fault qualification: overcurrent while commanded on and
 * open load while off, each confirmed after a persistence time.
 * Assumes detector inputs are already synchronous to clk.
 */
`timescale 1ns/1ps
module qld_chan_sense #(
    parameter int SENSE_CYC = 12500
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic chanOn,
    input wire logic ocDet,
    input wire logic olDet,
    output logic ocHit,
    output logic olHit
);
    import qld_pkg::*;

    localparam int CW = $clog2(SENSE_CYC + 1);
    localparam logic [CW-1:0] LIMIT = CW'(SENSE_CYC);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] ocCnt_reg, ocCnt_next;
    logic [CW-1:0] olCnt_reg, olCnt_next;

    // ************************************************************
    // Persistence counters
    // ************************************************************
    // Count while condition holds, restart when it drops
    always_comb begin
        ocCnt_next = '0;
        olCnt_next = '0;
        if (chanOn && ocDet) begin
            ocCnt_next = (ocCnt_reg == LIMIT) ? LIMIT : ocCnt_reg + ONE;
        end
        if (!chanOn && olDet) begin
            olCnt_next = (olCnt_reg == LIMIT) ? LIMIT : olCnt_reg + ONE;
        end
    end

    // Register counters
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ocCnt_reg <= '0;
            olCnt_reg <= '0;
        end else begin
            ocCnt_reg <= ocCnt_next;
            olCnt_reg <= olCnt_next;
        end
    end

    // Confirmed conditions
    assign ocHit = (ocCnt_reg == LIMIT);
    assign olHit = (olCnt_reg == LIMIT);

endmodule

// [tb/qld_host_model.sv]
/*
 * Host side of the serial command port: a bus master that frames
 * 8 or 16 bit words and collects what the driver returns.
 * Assumes the driver samples select and shift clock with clk.
 */
`timescale 1ns/1ps
module qld_host_model (
    input wire logic clk,
    output logic select_n,
    output logic sclk,
    output logic serIn,
    input wire logic serOut,
    input wire logic serOutOe
);
    // Idle: deselected, clock parked low, data pulled down
    initial begin
        select_n = 1'h1;
        sclk = 1'h0;
        serIn = 1'h0;
    end

    // One frame, MSB first; returned bits read as X when not driven
    task automatic xfer(input int nBits, input logic [15:0] txWord,
                        output logic [15:0] rxWord);
        rxWord = 16'h0000;
        @(posedge clk);
        select_n <= 1'h0;
        for (int i = nBits - 1; i >= 0; i--) begin
            @(posedge clk);
            serIn <= txWord[i];
            repeat (4) @(posedge clk);
            rxWord = {rxWord[14:0], serOutOe ? serOut : 1'hx};
            sclk <= 1'h1;
            repeat (4) @(posedge clk);
            sclk <= 1'h0;
        end
        repeat (4) @(posedge clk);
        select_n <= 1'h1;
        serIn <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
endmodule

// [tb/test_quad_low_side_driver_serial_ctrl.sv]
/*
 * Self-checking bench for the quad low-side driver control block.
 * Assumes the shortened sense and duty parameters set below.
 */
`timescale 1ns/1ps
module test_quad_low_side_driver_serial_ctrl;
    import qld_pkg::*;
    logic clk, reset_n, select_n, sclk, serIn, serOut, serOutOe;
    logic [3:0] parCtl, drvCh, ocDet, olDet;
    logic overvoltage, statusOut, statusOe, wbAck, irq;
    qld_wb_req_t wbReq;
    logic [31:0] wbDatOut, rd;
    logic [15:0] rx;
    int bad_count = 0;
    int n_checks = 0;
    int onCnt;

    // ************************************************************
    // Design and host
    // ************************************************************
    qld_driver_ctrl #(.SENSE_CYC(20), .DUTY_TICK_CYC(2)) dut (
        .clk(clk), .reset_n(reset_n), .select_n(select_n), .sclk(sclk),
        .serIn(serIn), .serOut(serOut), .serOutOe(serOutOe),
        .parCtl(parCtl), .drvCh(drvCh), .ocDet(ocDet), .olDet(olDet),
        .overvoltage(overvoltage), .statusOut(statusOut),
        .statusOe(statusOe), .wbReq(wbReq), .wbDatOut(wbDatOut),
        .wbAck(wbAck), .irq(irq)
    );
    qld_host_model host (
        .clk(clk), .select_n(select_n), .sclk(sclk), .serIn(serIn),
        .serOut(serOut), .serOutOe(serOutOe)
    );

    // 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] rdat);
        @(posedge clk);
        wbReq <= '{cyc:1'h1, stb:1'h1, we:we, adr:adr, sel:4'hF, dat:dat};
        do @(posedge clk); while (wbAck !== 1'h1);
        rdat = wbDatOut;
        wbReq.cyc <= 1'h0;
        wbReq.stb <= 1'h0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_reset();
        chk({drvCh, serOutOe, statusOe, statusOut, irq, wbAck}, 32'h0);
        wb(1'h0, ADR_STATE, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'h1, 8'h10, 32'hFFFF_FFFF, rd);
        wb(1'h0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    task automatic test_serial_cmd();
        host.xfer(8, 16'h00F5, rx);
        chk({16'h0, rx}, 32'h0);
        repeat (4) @(posedge clk);
        chk({28'h0, drvCh}, 32'h5);
        chk({31'h0, serOutOe}, 32'h0);
    endtask

    task automatic test_parallel_ov();
        parCtl <= 4'hA;
        repeat (4) @(posedge clk);
        chk({28'h0, drvCh}, 32'hF);
        overvoltage <= 1'h1;
        repeat (3) @(posedge clk);
        chk({28'h0, drvCh}, 32'h0);
        overvoltage <= 1'h0;
        repeat (3) @(posedge clk);
        chk({28'h0, drvCh}, 32'hF);
        parCtl <= 4'h0;
        repeat (3) @(posedge clk);
        chk({28'h0, drvCh}, 32'h5);
    endtask

    task automatic test_overcurrent();
        ocDet <= 4'h1;
        repeat (30) @(posedge clk);
        chk({31'h0, statusOe}, 32'h1);
        chk({31'h0, statusOut}, 32'h0);
        onCnt = 0;
        // Two full duty periods of 64 slots by 2 clocks
        repeat (256) begin
            @(posedge clk);
            onCnt += drvCh[0];
        end
        chk(onCnt, 32'h4);
        ocDet <= 4'h0;
        repeat (10) @(posedge clk);
        chk({28'h0, drvCh}, 32'h5);
        chk({31'h0, statusOe}, 32'h1);
        host.xfer(8, 16'h0000, rx);
        chk({16'h0, rx}, 32'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, statusOe}, 32'h0);
    endtask

    task automatic test_open_load();
        olDet <= 4'h4;
        repeat (30) @(posedge clk);
        chk({31'h0, statusOe}, 32'h1);
        olDet <= 4'h0;
        host.xfer(8, 16'h0000, rx);
        chk({16'h0, rx}, 32'h4);
    endtask

    task automatic test_echo();
        host.xfer(16, 16'hA503, rx);
        repeat (4) @(posedge clk);
        chk({28'h0, drvCh}, 32'h3);
        host.xfer(16, 16'h0000, rx);
        chk({16'h0, rx}, 32'h00A5);
        repeat (4) @(posedge clk);
        chk({28'h0, drvCh}, 32'h0);
    endtask

    task automatic test_irq();
        wb(1'h1, ADR_CLEAR, 32'h3F, rd);
        wb(1'h0, ADR_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'h1, ADR_ENABLE, 32'h20, rd);
        wb(1'h0, ADR_ENABLE, 32'h0, rd);
        chk(rd, 32'h20);
        host.xfer(8, 16'h0000, rx);
        chk({31'h0, irq}, 32'h1);
        wb(1'h0, ADR_STATUS, 32'h0, rd);
        chk(rd, 32'h20);
        wb(1'h1, ADR_CLEAR, 32'h20, rd);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wb(1'h1, ADR_ENABLE, 32'h0, rd);
        host.xfer(8, 16'h0000, rx);
        chk({31'h0, irq}, 32'h0);
        wb(1'h0, ADR_STATUS, 32'h0, rd);
        chk(rd, 32'h20);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        reset_n = 1'h0;
        parCtl = 4'h0;
        ocDet = 4'h0;
        olDet = 4'h0;
        overvoltage = 1'h0;
        wbReq = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        test_reset();
        test_serial_cmd();
        test_parallel_ov();
        test_overcurrent();
        test_open_load();
        test_echo();
        test_irq();
        stop_test();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule
